/* rtl/wdog_sup_pkg.sv */
/*
  Constants, register map and state encoding for the watchdog and reset supervisor.
  Assumes a 32-bit AHB-Lite register bus and one system clock at 125 MHz.
*/
// Contract
// - Supply below warning level with enable set requests interrupt, vector 33h.
// - Power-fail flag sets on each fall below warning level; software clears.
// - Supply below reset level asserts internal reset.
// - After supply recovers, hold reset 65,536 more cycles, then run from 0000h.
// - Power-on reset sets power-on flag; only software clears it.
// - In stop, monitors off if keep bit 0, reduced-on if 1.
// - Divide-by-1 default: interrupt after 2^17 clocks, reset 512 clocks later.
// - Each interval select step multiplies interval by eight; reset always 512 later.
// - Base interval follows clock mode: 2^15, 2^16, 2^17 or 2^27.
// - Any reset returns interval select to default.
// - Restart bit restarts watchdog for a full new interval.
// - Reset only if reset enable set; otherwise periodic interrupt time-outs.
// - Interrupt flag sets at interval end; reset flag after watchdog reset.
// - Watchdog interrupt forwarded only while watchdog interrupt enable is 1.
// - Start-up counter counts 65,536 clocks after power-up, stop exit, multiplier on.
// - System reset command in flash control resets, reorders banks, resumes 0000h.
// - Stay in reset while pin high; after release, run from 0000h.
// - Pin reset in stop starts oscillator, delays 65,536 clocks.
// - Power-fail, watchdog, system resets drive reset pin high while asserted.
// - Oscillator-fail detect enabled and slow crystal causes reset, held meanwhile.
// - Osc-fail flag cleared by software or power-on; enable by software or power-fail.
// - Protected bits change only within three cycles after AAh then 55h.
// - Reserved divide setting 01b acts as divide-by-1 setting 10b.
package wdog_sup_pkg;
  // byte offsets on the register bus
  localparam logic [7:0] OFS_WDOG_CTRL = 8'h00;
  localparam logic [7:0] OFS_EXT_INT_EN = 8'h04;
  localparam logic [7:0] OFS_EXT_INT_FLAG = 8'h08;
  localparam logic [7:0] OFS_PWR_CTRL = 8'h0C;
  localparam logic [7:0] OFS_CLK_CTRL = 8'h10;
  localparam logic [7:0] OFS_TIMED_ACC = 8'h14;
  localparam logic [7:0] OFS_FLASH_CTRL = 8'h18;
  localparam logic [7:0] OFS_CLK_MODE = 8'h1C;
  // field positions
  localparam int WDC_RESTART = 0;
  localparam int WDC_RST_EN = 1;
  localparam int WDC_RST_FLAG = 2;
  localparam int WDC_INT_FLAG = 3;
  localparam int WDC_PF_FLAG = 4;
  localparam int WDC_PF_EN = 5;
  localparam int WDC_POR_FLAG = 6;
  localparam int EIE_WD_INT_EN = 4;
  localparam int EXF_MON_KEEP = 0;
  localparam int PC_OF_EN = 4;
  localparam int PC_OF_FLAG = 5;
  localparam int CKC_WD_SEL_LSB = 6;
  localparam int FC_BANK_SEL = 7;
  localparam int CM_RATIO = 2;
  localparam int CM_MULT_EN = 3;
  localparam int CM_XTAL_RDY = 4;
  // values
  localparam logic [7:0] TA_KEY_FIRST = 8'hAA;
  localparam logic [7:0] TA_KEY_SECOND = 8'h55;
  localparam logic [1:0] TA_WINDOW = 2'h3;
  localparam logic [3:0] SYSRST_CMD = 4'h8;
  localparam logic [7:0] PWRFAIL_VECTOR = 8'h33;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [1:0] CD_DEFAULT = 2'h2;
  localparam logic [1:0] WD_SEL_DEFAULT = 2'h0;
  localparam logic [1:0] EXT_MIN_HIGH = 2'h3;
  // counts in clock cycles; watchdog intervals as power-of-two exponents
  localparam logic [36:0] WDOG_RST_GAP = 37'h0_0000_0200;
  localparam logic [5:0] WDOG_EXP_X4_DEF = 6'h0F;
  localparam logic [5:0] WDOG_EXP_X2_DEF = 6'h10;
  localparam logic [5:0] WDOG_EXP_DIV1_DEF = 6'h11;
  localparam logic [5:0] WDOG_EXP_DIV1024_DEF = 6'h1B;
  localparam logic [5:0] WDOG_EXP_STEP = 6'h03;
  localparam logic [16:0] POR_HOLD_DEF = 17'h10000;
  localparam logic [16:0] XTAL_START_DEF = 17'h10000;
  localparam logic [16:0] RST_HOLD_DEF = 17'h00010;

  typedef enum logic [2:0] {
    ST_SUPPLY    = 3'h0,
    ST_POR_HOLD  = 3'h1,
    ST_RUN       = 3'h2,
    ST_HOLD      = 3'h3,
    ST_EXT       = 3'h4,
    ST_OSC       = 3'h5,
    ST_STOP_WAKE = 3'h6
  } rst_state_t;
endpackage

/* rtl/watchdog_reset_supervisor.sv */
/*
  Watchdog timer, supply monitor reset sequencing, start-up counter, system reset
  command, bidirectional reset pin and oscillator-fail reset, with AHB-Lite registers.
  Assumes comparator, stop and slow-crystal inputs already synchronous to clk_sys,
  and that the core treats sys_reset as its reset and restarts at reset_vector.
*/
`timescale 1ns/10ps
`default_nettype none
module watchdog_reset_supervisor
  import wdog_sup_pkg::*;
#(
  parameter logic [16:0] POR_HOLD_CYCLES   = POR_HOLD_DEF,
  parameter logic [16:0] XTAL_START_CYCLES = XTAL_START_DEF,
  parameter logic [16:0] RST_HOLD_CYCLES   = RST_HOLD_DEF,
  parameter logic [5:0]  WDOG_EXP_X4       = WDOG_EXP_X4_DEF,
  parameter logic [5:0]  WDOG_EXP_X2       = WDOG_EXP_X2_DEF,
  parameter logic [5:0]  WDOG_EXP_DIV1     = WDOG_EXP_DIV1_DEF,
  parameter logic [5:0]  WDOG_EXP_DIV1024  = WDOG_EXP_DIV1024_DEF
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  // supply comparators and core status
  input  wire logic        pwr_warn_below,
  input  wire logic        pwr_rst_below,
  input  wire logic        stop_mode,
  input  wire logic        xtal_slow,
  // reset pin
  input  wire logic        rst_pin_i,
  output var  logic        rst_pin_o,
  output var  logic        rst_pin_oe,
  // to the core
  output var  logic        sys_reset,
  output var  logic [15:0] reset_vector,
  output var  logic        bank_order,
  output var  logic        pwrfail_irq,
  output var  logic [7:0]  pwrfail_irq_vector,
  output var  logic        wdog_irq,
  // analog and clock control
  output var  logic        monitor_enable,
  output var  logic        monitor_reduced,
  output var  logic        xtal_osc_enable,
  output var  logic        xtal_ready,
  output var  logic        ring_osc_hold
);

  rst_state_t  state_r;
  rst_state_t  state_nxt;
  logic [16:0] hold_cnt_r;
  logic [16:0] xs_cnt_r;
  logic [36:0] wd_cnt_r;
  logic        wd_phase_r;
  logic [1:0]  ext_cnt_r;
  logic [1:0]  ta_arm_r;
  logic [1:0]  ta_open_r;
  logic        wr_pend_r;
  logic [7:0]  wr_addr_r;
  logic [31:0] hrdata_r;
  logic        drive_r;
  logic        sys_src_r;
  logic        sys_reset_r;
  logic        warn_q_r;
  logic        mult_q_r;
  logic        stop_q_r;
  logic        mon_en_r;
  logic        mon_red_r;
  logic        sysrst_req_r;
  logic        bank_sel_r;
  logic        bank_order_r;
  logic        pf_irq_r;
  logic [7:0]  pf_vec_r;
  logic        wd_irq_r;
  logic        xosc_en_r;
  // register bits
  logic        pf_en_r;
  logic        pf_flag_r;
  logic        wd_rst_en_r;
  logic        wd_int_flag_r;
  logic        wd_rst_flag_r;
  logic        por_flag_r;
  logic        wd_int_en_r;
  logic        mon_keep_r;
  logic        of_en_r;
  logic        of_flag_r;
  logic [1:0]  wd_sel_r;
  logic [1:0]  cd_sel_r;
  logic        ratio_r;
  logic        mult_en_r;
  logic [3:0]  flash_cmd_r;

  logic        sup_low;
  logic        warn_low;
  logic        pin_high;
  logic        ext_req;
  logic        osc_evt;
  logic        wd_int_evt;
  logic        wd_rst_evt;
  logic        hold_done;
  logic        xs_restart;
  logic        ta_ok;
  logic        rd_take;
  logic        we_wdc;
  logic        we_eie;
  logic        we_exf;
  logic        we_pc;
  logic        we_ckc;
  logic        we_ta;
  logic        we_fc;
  logic        we_cm;
  logic        restart_pulse;
  logic [5:0]  wd_base;
  logic [5:0]  wd_exp;
  logic [36:0] wd_limit;
  logic [31:0] rd_word;

  // comparators are ignored while stop mode has them powered down
  assign sup_low  = mon_en_r & pwr_rst_below;
  assign warn_low = mon_en_r & pwr_warn_below;
  // our own drive of the pin must not look like an external reset
  assign pin_high = rst_pin_i & ~rst_pin_oe;
  assign ext_req  = (ext_cnt_r == EXT_MIN_HIGH);
  assign osc_evt  = of_en_r & xtal_slow & ~stop_mode;
  assign ta_ok    = (ta_open_r != 2'h0);
  assign rd_take  = hsel & hready & htrans[1] & ~hwrite;

  assign we_wdc = wr_pend_r & (wr_addr_r == OFS_WDOG_CTRL);
  assign we_eie = wr_pend_r & (wr_addr_r == OFS_EXT_INT_EN);
  assign we_exf = wr_pend_r & (wr_addr_r == OFS_EXT_INT_FLAG);
  assign we_pc  = wr_pend_r & (wr_addr_r == OFS_PWR_CTRL);
  assign we_ckc = wr_pend_r & (wr_addr_r == OFS_CLK_CTRL);
  assign we_ta  = wr_pend_r & (wr_addr_r == OFS_TIMED_ACC);
  assign we_fc  = wr_pend_r & (wr_addr_r == OFS_FLASH_CTRL);
  assign we_cm  = wr_pend_r & (wr_addr_r == OFS_CLK_MODE);
  assign restart_pulse = we_wdc & ta_ok & hwdata[WDC_RESTART];

  // watchdog interval from clock mode and interval select
  always_comb begin
    unique case (cd_sel_r)
      2'h0:    wd_base = ratio_r ? WDOG_EXP_X4 : WDOG_EXP_X2;
      2'h3:    wd_base = WDOG_EXP_DIV1024;
      default: wd_base = WDOG_EXP_DIV1;
    endcase
  end
  assign wd_exp     = wd_base + ({4'h0, wd_sel_r} * WDOG_EXP_STEP);
  assign wd_limit   = 37'h0_0000_0001 << wd_exp;
  assign wd_int_evt = ~sys_reset_r & ~wd_phase_r & (wd_cnt_r == wd_limit - 37'h1);
  assign wd_rst_evt = ~sys_reset_r & wd_phase_r & wd_rst_en_r
                      & (wd_cnt_r == WDOG_RST_GAP - 37'h1);

  assign hold_done = (state_r == ST_POR_HOLD) ? (hold_cnt_r == POR_HOLD_CYCLES - 17'h1)
                                              : (hold_cnt_r == RST_HOLD_CYCLES - 17'h1);

  // reset sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_SUPPLY: begin
        if (!sup_low) state_nxt = ST_POR_HOLD;
      end
      ST_POR_HOLD: begin
        if (hold_done) state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (wd_rst_evt) state_nxt = ST_HOLD;
        else if (osc_evt) state_nxt = ST_OSC;
        else if (sysrst_req_r) state_nxt = ST_HOLD;
        else if (ext_req) state_nxt = stop_mode ? ST_STOP_WAKE : ST_EXT;
      end
      ST_HOLD: begin
        if (hold_done) state_nxt = ST_RUN;
      end
      ST_EXT: begin
        if (!pin_high) state_nxt = ST_HOLD;
      end
      ST_OSC: begin
        if (!xtal_slow) state_nxt = ST_HOLD;
      end
      ST_STOP_WAKE: begin
        if (xtal_ready) state_nxt = ST_RUN;
      end
      default: state_nxt = ST_SUPPLY;
    endcase
    if (sup_low) state_nxt = ST_SUPPLY;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) state_r <= ST_SUPPLY;
    else state_r <= state_nxt;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) hold_cnt_r <= 17'h0;
    else if (state_nxt != state_r) hold_cnt_r <= 17'h0;
    else if ((state_r == ST_POR_HOLD) || (state_r == ST_HOLD)) hold_cnt_r <= hold_cnt_r + 17'h1;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) sys_reset_r <= 1'b1;
    else sys_reset_r <= (state_nxt != ST_RUN);
  end

  // pin drive follows supply, watchdog and system resets only, not oscillator-fail resets
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) drive_r <= 1'b1;
    else if (state_nxt == ST_SUPPLY) drive_r <= 1'b1;
    else if ((state_r == ST_RUN) && (state_nxt == ST_HOLD)) drive_r <= 1'b1;
    else if (state_nxt != ST_HOLD && state_nxt != ST_POR_HOLD) drive_r <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) sys_src_r <= 1'b0;
    else if (state_r == ST_RUN) sys_src_r <= ~wd_rst_evt & ~osc_evt & sysrst_req_r;
  end

  // bank order is taken up as the system reset command releases
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) bank_order_r <= 1'b0;
    else if (sys_src_r && (state_r == ST_HOLD) && (state_nxt == ST_RUN))
      bank_order_r <= bank_sel_r;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) ext_cnt_r <= 2'h0;
    else if (!pin_high) ext_cnt_r <= 2'h0;
    else if (ext_cnt_r != EXT_MIN_HIGH) ext_cnt_r <= ext_cnt_r + 2'h1;
  end

  // crystal start-up counter
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stop_q_r <= 1'b0;
      mult_q_r <= 1'b0;
    end else begin
      stop_q_r <= stop_mode;
      mult_q_r <= mult_en_r;
    end
  end
  assign xs_restart = (state_nxt == ST_SUPPLY) || (stop_q_r && !stop_mode)
                      || (mult_en_r && !mult_q_r)
                      || ((state_r == ST_RUN) && (state_nxt == ST_STOP_WAKE));

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) xs_cnt_r <= 17'h0;
    else if (xs_restart) xs_cnt_r <= 17'h0;
    else if (xs_cnt_r != XTAL_START_CYCLES) xs_cnt_r <= xs_cnt_r + 17'h1;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) xtal_ready <= 1'b0;
    else xtal_ready <= ~xs_restart & (xs_cnt_r >= XTAL_START_CYCLES - 17'h1);
  end

  // oscillator stops in stop mode unless a pin reset wakes it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) xosc_en_r <= 1'b1;
    else xosc_en_r <= ~stop_mode | (state_nxt == ST_STOP_WAKE);
  end

  // watchdog counter
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wd_cnt_r   <= 37'h0;
      wd_phase_r <= 1'b0;
    end else if (sys_reset_r || restart_pulse) begin
      wd_cnt_r   <= 37'h0;
      wd_phase_r <= 1'b0;
    end else if (wd_int_evt) begin
      wd_cnt_r   <= 37'h0;
      wd_phase_r <= wd_rst_en_r;
    end else if (wd_phase_r && !wd_rst_en_r) begin
      wd_cnt_r   <= 37'h0;
      wd_phase_r <= 1'b0;
    end else begin
      wd_cnt_r   <= wd_cnt_r + 37'h1;
    end
  end

  // timed access sequence
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ta_arm_r  <= 2'h0;
      ta_open_r <= 2'h0;
    end else begin
      if (we_ta && hwdata[7:0] == TA_KEY_FIRST) ta_arm_r <= TA_WINDOW;
      else if (we_ta) ta_arm_r <= 2'h0;
      else if (ta_arm_r != 2'h0) ta_arm_r <= ta_arm_r - 2'h1;
      if (we_ta && hwdata[7:0] == TA_KEY_SECOND && ta_arm_r != 2'h0) ta_open_r <= TA_WINDOW;
      else if (ta_open_r != 2'h0) ta_open_r <= ta_open_r - 2'h1;
    end
  end

  // power-fail flag and enable
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) warn_q_r <= 1'b0;
    else warn_q_r <= warn_low;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) pf_flag_r <= 1'b0;
    else if (warn_low && !warn_q_r) pf_flag_r <= 1'b1;
    else if (we_wdc && !hwdata[WDC_PF_FLAG]) pf_flag_r <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) pf_en_r <= 1'b0;
    else if (we_wdc) pf_en_r <= hwdata[WDC_PF_EN];
  end

  // watchdog control bits; hardware set wins over a software clear
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) wd_rst_en_r <= 1'b0;
    else if (we_wdc && ta_ok) wd_rst_en_r <= hwdata[WDC_RST_EN];
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) wd_int_flag_r <= 1'b0;
    else if (wd_int_evt) wd_int_flag_r <= 1'b1;
    else if (we_wdc && ta_ok) wd_int_flag_r <= hwdata[WDC_INT_FLAG];
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) wd_rst_flag_r <= 1'b0;
    else if (wd_rst_evt && state_r == ST_RUN) wd_rst_flag_r <= 1'b1;
    else if (we_wdc) wd_rst_flag_r <= hwdata[WDC_RST_FLAG];
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) por_flag_r <= 1'b1;
    else if (state_nxt == ST_SUPPLY) por_flag_r <= 1'b1;
    else if (we_wdc && ta_ok) por_flag_r <= hwdata[WDC_POR_FLAG];
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) wd_int_en_r <= 1'b0;
    else if (we_eie) wd_int_en_r <= hwdata[EIE_WD_INT_EN];
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) mon_keep_r <= 1'b0;
    else if (we_exf && ta_ok) mon_keep_r <= hwdata[EXF_MON_KEEP];
  end

  // oscillator-fail bits
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) of_en_r <= 1'b0;
    else if (state_nxt == ST_SUPPLY) of_en_r <= 1'b0;
    else if (we_pc) of_en_r <= hwdata[PC_OF_EN];
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) of_flag_r <= 1'b0;
    else if (osc_evt && state_r == ST_RUN && !sup_low) of_flag_r <= 1'b1;
    else if (state_nxt == ST_SUPPLY) of_flag_r <= 1'b0;
    else if (we_pc) of_flag_r <= hwdata[PC_OF_FLAG];
  end

  // interval select and clock mode return to defaults on any reset
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) wd_sel_r <= WD_SEL_DEFAULT;
    else if (sys_reset_r) wd_sel_r <= WD_SEL_DEFAULT;
    else if (we_ckc) wd_sel_r <= hwdata[CKC_WD_SEL_LSB +: 2];
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cd_sel_r  <= CD_DEFAULT;
      ratio_r   <= 1'b0;
      mult_en_r <= 1'b0;
    end else if (sys_reset_r) begin
      cd_sel_r  <= CD_DEFAULT;
      ratio_r   <= 1'b0;
      mult_en_r <= 1'b0;
    end else if (we_cm) begin
      cd_sel_r  <= hwdata[1:0];
      mult_en_r <= hwdata[CM_MULT_EN];
      // the ratio may only move while the multiplier is off
      if (!mult_en_r) ratio_r <= hwdata[CM_RATIO];
    end
  end

  // flash control: system reset command and bank select
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flash_cmd_r  <= 4'h0;
      sysrst_req_r <= 1'b0;
    end else begin
      if (we_fc && ta_ok) flash_cmd_r <= hwdata[3:0];
      if (state_r != ST_RUN) sysrst_req_r <= 1'b0;
      else if (we_fc && ta_ok && hwdata[3:0] == SYSRST_CMD) sysrst_req_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) bank_sel_r <= 1'b0;
    else if (we_fc) bank_sel_r <= hwdata[FC_BANK_SEL];
  end

  // monitor power in stop mode
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mon_en_r  <= 1'b1;
      mon_red_r <= 1'b0;
    end else begin
      mon_en_r  <= ~stop_mode | mon_keep_r;
      mon_red_r <= stop_mode & mon_keep_r;
    end
  end

  // interrupt requests
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pf_irq_r <= 1'b0;
      pf_vec_r <= 8'h00;
      wd_irq_r <= 1'b0;
    end else begin
      pf_irq_r <= warn_low & pf_en_r;
      pf_vec_r <= (warn_low & pf_en_r) ? PWRFAIL_VECTOR : 8'h00;
      wd_irq_r <= wd_int_flag_r & wd_int_en_r;
    end
  end

  // bus slave: zero wait states, write applied at the end of the data phase
  always_comb begin
    rd_word = 32'h0;
    unique case (haddr[7:0])
      OFS_WDOG_CTRL: begin
        rd_word[WDC_RST_EN]   = wd_rst_en_r;
        rd_word[WDC_RST_FLAG] = wd_rst_flag_r;
        rd_word[WDC_INT_FLAG] = wd_int_flag_r;
        rd_word[WDC_PF_FLAG]  = pf_flag_r;
        rd_word[WDC_PF_EN]    = pf_en_r;
        rd_word[WDC_POR_FLAG] = por_flag_r;
      end
      OFS_EXT_INT_EN:   rd_word[EIE_WD_INT_EN] = wd_int_en_r;
      OFS_EXT_INT_FLAG: rd_word[EXF_MON_KEEP] = mon_keep_r;
      OFS_PWR_CTRL:     rd_word[PC_OF_FLAG:PC_OF_EN] = {of_flag_r, of_en_r};
      OFS_CLK_CTRL:     rd_word[CKC_WD_SEL_LSB +: 2] = wd_sel_r;
      OFS_TIMED_ACC:    rd_word[0] = ta_ok;
      OFS_FLASH_CTRL:   rd_word[7:0] = {bank_sel_r, 3'h0, flash_cmd_r};
      OFS_CLK_MODE:     rd_word[CM_XTAL_RDY:0] = {xtal_ready, mult_en_r, ratio_r, cd_sel_r};
      default:          rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else if (hready) begin
      wr_pend_r <= hsel & htrans[1] & hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) hrdata_r <= 32'h0;
    else if (rd_take) hrdata_r <= rd_word;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reset_vector  <= RESET_VECTOR;
      ring_osc_hold <= 1'b0;
    end else begin
      reset_vector  <= RESET_VECTOR;
      ring_osc_hold <= (state_nxt == ST_OSC);
    end
  end

  assign hrdata             = hrdata_r;
  assign rst_pin_o          = drive_r;
  assign rst_pin_oe         = drive_r;
  assign sys_reset          = sys_reset_r;
  assign bank_order         = bank_order_r;
  assign pwrfail_irq        = pf_irq_r;
  assign pwrfail_irq_vector = pf_vec_r;
  assign wdog_irq           = wd_irq_r;
  assign monitor_enable     = mon_en_r;
  assign monitor_reduced    = mon_red_r;
  assign xtal_osc_enable    = xosc_en_r;

  // hsize is accepted but only whole-word transfers are supported
  logic unused_ok;
  assign unused_ok = &{1'b0, hsize, haddr[31:8], hwdata[31:8]};

endmodule
`default_nettype wire

/* tb/wdog_sup_sva.sv */
/* Port checker for the supervisor; bound to its top module, sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module wdog_sup_sva (
  // watched ports
  input wire logic clk_sys, rst_b, pwr_rst_below, stop_mode, rst_pin_i, rst_pin_oe,
  input wire logic sys_reset, pwrfail_irq, monitor_enable, monitor_reduced,
  input wire logic xtal_ready, ring_osc_hold, wdog_irq,
  input wire logic [15:0] reset_vector,
  input wire logic [7:0] pwrfail_irq_vector
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  property p_pf_vec; pwrfail_irq |-> pwrfail_irq_vector == 8'h33; endproperty
  a_pf_vec: assert property (p_pf_vec) else $error("bad vector");
  property p_supply; monitor_enable && pwr_rst_below |-> ##[1:3] sys_reset; endproperty
  a_supply: assert property (p_supply) else $error("no supply reset");
  property p_vec; $fell(sys_reset) |-> reset_vector == 16'h0000; endproperty
  a_vec: assert property (p_vec) else $error("bad restart");
  property p_stop; stop_mode [*2] |-> monitor_enable == monitor_reduced; endproperty
  a_stop: assert property (p_stop) else $error("monitor power");
  property p_xtal; $fell(stop_mode) |-> ##[1:3] !xtal_ready; endproperty
  a_xtal: assert property (p_xtal) else $error("no restart count");
  property p_ext; (rst_pin_i && !rst_pin_oe) [*3] |-> ##[0:2] sys_reset; endproperty
  a_ext: assert property (p_ext) else $error("pin reset missed");
  property p_pin; rst_pin_oe |-> sys_reset; endproperty
  a_pin: assert property (p_pin) else $error("pin driven outside reset");
  property p_ring; ring_osc_hold |-> sys_reset; endproperty
  a_ring: assert property (p_ring) else $error("hold without reset");
  c_wdog: cover property (wdog_irq);
  c_ring: cover property (ring_osc_hold);
  c_drive: cover property (rst_pin_oe && !pwr_rst_below);
endmodule
bind watchdog_reset_supervisor wdog_sup_sva u_sva (.clk_sys, .rst_b, .pwr_rst_below,
  .stop_mode, .rst_pin_i, .rst_pin_oe, .sys_reset, .pwrfail_irq, .monitor_enable,
  .monitor_reduced, .xtal_ready, .ring_osc_hold, .wdog_irq, .reset_vector, .pwrfail_irq_vector);
`default_nettype wire

/* tb/sup_far_model.sv */
/* Far side of the reset pin: external driver only, no pull-down. Bench drives ext_drv. */
`timescale 1ns/10ps
`default_nettype none
module sup_far_model (
  input wire logic ext_drv, rst_pin_o, rst_pin_oe,
  output logic     rst_pin_i
);
  // released pin follows ext_drv at once, no stale value survives
  assign rst_pin_i = rst_pin_oe ? rst_pin_o : ext_drv;
endmodule
`default_nettype wire

/* tb/tb_top.sv */
/* Self-checking bench for the supervisor; assumes shortened counts set below. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0, rst_b = 1'b0, hwrite = 1'b0, pwr_warn_below = 1'b0;
  logic pwr_rst_below = 1'b0, stop_mode = 1'b0, xtal_slow = 1'b0, ext_drv = 1'b0, hsel = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, r, hrdata;
  logic hreadyout, hresp, rst_pin_i, rst_pin_o, rst_pin_oe, sys_reset, bank_order, wdog_irq;
  logic pwrfail_irq, monitor_enable, monitor_reduced, xtal_ready, ring_osc_hold, xtal_osc_enable;
  logic [15:0] reset_vector;
  logic [7:0] pwrfail_irq_vector;
  int bad_count = 0, tests_run = 0, n;
  always #4 clk_sys = ~clk_sys;
  sup_far_model far (.ext_drv, .rst_pin_o, .rst_pin_oe, .rst_pin_i);
  watchdog_reset_supervisor #(.POR_HOLD_CYCLES(17'h10), .XTAL_START_CYCLES(17'h10),
    .RST_HOLD_CYCLES(17'h4), .WDOG_EXP_DIV1(6'h6)) dut (.clk_sys, .rst_b, .hsel,
    .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .pwr_warn_below, .pwr_rst_below, .stop_mode, .xtal_slow,
    .rst_pin_i, .rst_pin_o, .rst_pin_oe, .sys_reset, .reset_vector, .bank_order,
    .pwrfail_irq, .pwrfail_irq_vector, .wdog_irq, .monitor_enable, .monitor_reduced,
    .xtal_osc_enable, .xtal_ready, .ring_osc_hold);
  task tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task ck(input logic [31:0] g, e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one single transfer; entered right after a rising edge
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task rdck(input logic [7:0] a, m, e);
    xfer(a, 1'b0, 32'h0);
    ck({hresp, r[7:0] & m}, {1'b0, e});
  endtask
  task ta();
    xfer(8'h14, 1'b1, 32'hAA);
    xfer(8'h14, 1'b1, 32'h55);
  endtask
  // s: 0 watchdog irq, 1 reset up, 2 reset down
  task wt(input int s);
    n = 0;
    while ((s == 0 ? wdog_irq : s == 1 ? sys_reset : ~sys_reset) !== 1'b1 && n < 9000) begin
      @(posedge clk_sys);
      n++;
    end
    // a wait that runs out is a mismatch of its own
    ck(n < 9000, 1'b1);
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  initial begin
    #100000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    cyc(16);
    rst_b <= 1'b1;
    wt(2);
    rdck(8'h00, 8'hFF, 8'h40);
    rdck(8'h40, 8'hFF, 8'h00);
    xfer(8'h00, 1'b1, 32'h20);
    pwr_warn_below <= 1'b1;
    cyc(3);
    ck({pwrfail_irq, pwrfail_irq_vector}, 9'h133);
    pwr_warn_below <= 1'b0;
    rdck(8'h00, 8'hFF, 8'h70);
    xfer(8'h00, 1'b1, 32'h20);
    rdck(8'h00, 8'hFF, 8'h60);
    xfer(8'h04, 1'b1, 32'h10);
    hsel <= 1'b0;
    xfer(8'h04, 1'b1, 32'h0);
    hsel <= 1'b1;
    rdck(8'h04, 8'hFF, 8'h10);
    ta();
    xfer(8'h00, 1'b1, 32'h21);
    wt(0);
    ck(n >= 60 && n <= 68, 1);
    rdck(8'h00, 8'h48, 8'h08);
    xfer(8'h10, 1'b1, 32'h40);
    ta();
    xfer(8'h00, 1'b1, 32'h21);
    // the request from the cleared flag stands one more edge
    cyc(2);
    wt(0);
    ck(n >= 508 && n <= 516, 1);
    ta();
    xfer(8'h00, 1'b1, 32'h23);
    cyc(2);
    wt(0);
    wt(1);
    ck(n >= 508 && n <= 516, 1);
    wt(2);
    rdck(8'h00, 8'h04, 8'h04);
    rdck(8'h10, 8'hFF, 8'h00);
    ta();
    xfer(8'h00, 1'b1, 32'h01);
    ext_drv <= 1'b1;
    cyc(6);
    ck({sys_reset, rst_pin_oe}, 2'b10);
    ext_drv <= 1'b0;
    wt(2);
    stop_mode <= 1'b1;
    cyc(3);
    ck({monitor_enable, xtal_osc_enable}, 2'b00);
    stop_mode <= 1'b0;
    cyc(3);
    ck(xtal_ready, 1'b0);
    cyc(20);
    ck(xtal_ready, 1'b1);
    ta();
    xfer(8'h08, 1'b1, 32'h1);
    stop_mode <= 1'b1;
    cyc(3);
    ck({monitor_enable, monitor_reduced}, 2'b11);
    ext_drv <= 1'b1;
    cyc(6);
    ck({sys_reset, xtal_osc_enable, rst_pin_oe}, 3'b110);
    ext_drv <= 1'b0;
    wt(2);
    stop_mode <= 1'b0;
    xfer(8'h0C, 1'b1, 32'h10);
    xtal_slow <= 1'b1;
    cyc(3);
    ck({ring_osc_hold, sys_reset}, 2'b11);
    xtal_slow <= 1'b0;
    wt(2);
    rdck(8'h0C, 8'hFF, 8'h30);
    ta();
    xfer(8'h18, 1'b1, 32'h88);
    cyc(2);
    ck(sys_reset, 1'b1);
    wt(2);
    ck(bank_order, 1'b1);
    pwr_rst_below <= 1'b1;
    cyc(3);
    ck(sys_reset, 1'b1);
    pwr_rst_below <= 1'b0;
    wt(2);
    rdck(8'h0C, 8'hFF, 8'h00);
    rdck(8'h00, 8'h40, 8'h40);
    tally_and_finish();
  end
endmodule
`default_nettype wire
